// >>> pkg/dcpm_pkg.sv
// constants and types for the direct-control pin mode block
package dcpm_pkg;

    localparam int          DCPM_REG_W        = 8;
    localparam int          DCPM_FREQ_W       = 4;
    localparam int          DCPM_PIN_W        = 5;
    localparam int          DCPM_SYNC_STAGES  = 3;

    // general control register bit positions
    localparam int          GEN_MOD_EN_BIT    = 0;
    localparam int          GEN_BIAS_EN_BIT   = 4;
    localparam int          GEN_DIV2_BIT      = 6;

    localparam logic [7:0]  GEN_WRITE_MASK    = 8'h51;
    localparam logic [7:0]  TX_WRITE_MASK     = 8'h0F;
    localparam logic [7:0]  GEN_RESET_VAL     = 8'h00;
    localparam logic [7:0]  TX_RESET_VAL      = 8'h00;
    // direct mode: everything held at reset except bias and modulator enables
    localparam logic [7:0]  GEN_DIRECT_VAL    = 8'h11;
    localparam logic [1:0]  FREQ_UPPER_DIRECT = 2'h0;

    // shared pin indices in the synchronised vector
    localparam int          PIN_FREQ_LO       = 0;
    localparam int          PIN_LOW_POWER_N   = 1;
    localparam int          PIN_DIV_SELECT    = 2;
    localparam int          PIN_FREQ_HI       = 3;
    localparam int          PIN_BUS_DISABLE_N = 4;
    // idle levels: bus enabled, select inactive, not in low power
    localparam logic [4:0]  PIN_SYNC_RESET    = 5'h1A;

    typedef enum logic [0:0] {
        DCPM_MODE_SERIAL = 1'b0,
        DCPM_MODE_DIRECT = 1'b1
    } dcpm_mode_t;

endpackage : dcpm_pkg

// >>> pkg/dcpm_sync_if.sv
// carrier for synchronised pin levels between the synchroniser and the mode logic
`timescale 1ns/10ps
interface dcpm_sync_if #(
    parameter int WIDTH = 5
);
    logic [WIDTH-1:0] pinLevel;

    modport source (output pinLevel);
    modport sink   (input  pinLevel);
endinterface : dcpm_sync_if

// >>> logic/dcpm_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module dcpm_pin_sync
    import dcpm_pkg::*;
#(
    parameter int               WIDTH     = 5,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinRaw,
    dcpm_sync_if.source           syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
                level_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
            level_reg  <= RESET_VAL;
        end else begin
            stage1_reg <= pinRaw;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= level_next;
        end
    end

    assign syncOut.pinLevel = level_reg;

endmodule : dcpm_pin_sync

// >>> logic/dcpm_direct_control.sv
// shared-pin mode selection, register hold and direct-control decode
//
// Contract
// - A low serial-bus disable level turns off the serial bus and gives the four shared pins their direct-control meaning.
// - While that input is low, the bias supplies and the modulator are enabled as if their two general control bits were one.
// - While that input is low, every register is held at its reset value except the bias and modulator enables, which stay set.
// - In direct mode the first frequency pin drives bit 0 of the LO path frequency field.
// - In direct mode the second frequency pin drives bit 1 of that field, giving four settings with the first pin.
// - In direct mode a low level on the low-power pin puts the device in low power, and the outside party must always drive that pin.
// - In direct mode a low divider-select pin picks divide-by-two and a high one divide-by-four, the inverse of general control bit 6.
// - The serial-bus disable input reads high when nobody drives it, so an open pin selects serial operation.
// - Reset clears every bit of every register and leaves the device in powersave.
// - General control bit 6 set selects divide-by-two and clear selects divide-by-four.
`timescale 1ns/10ps
module dcpm_direct_control
    import dcpm_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // shared pins
    input  wire logic                   serialBusDisableNPin,
    input  wire logic                   serialBusDisableNDriven,
    input  wire logic                   pinCmdFreqLo,
    input  wire logic                   pinClkLowPowerN,
    input  wire logic                   pinDataDivSelIn,
    output logic                        pinDataDivSelOut,
    output logic                        pinDataDivSelOe,
    input  wire logic                   pinSelectFreqHi,
    // serial engine side
    input  wire logic                   generalReset,
    input  wire logic                   wrGenCtrl,
    input  wire logic                   wrTxCtrl,
    input  wire logic [DCPM_REG_W-1:0]  wrData,
    input  wire logic                   serialDataOut,
    output logic                        serialCmdIn,
    output logic                        serialClk,
    output logic                        serialSelectN,
    // control outputs to the analogue sections
    output logic                        directMode,
    output logic                        biasSupplyEnable,
    output logic                        modulatorEnable,
    output logic                        loDivideByTwo,
    output logic [DCPM_FREQ_W-1:0]      loPathFreq,
    output logic                        lowPower,
    output logic                        powersave,
    output logic [DCPM_REG_W-1:0]       genCtrlRead,
    output logic [DCPM_REG_W-1:0]       txCtrlRead
);

    dcpm_sync_if #(.WIDTH(DCPM_PIN_W)) syncBus ();

    logic [DCPM_PIN_W-1:0] pinRaw;
    logic                  busDisableNEff;

    // an undriven disable pin floats high through its pull-up
    assign busDisableNEff = serialBusDisableNDriven ? serialBusDisableNPin : 1'b1;

    always_comb begin
        pinRaw                    = '0;
        pinRaw[PIN_FREQ_LO]       = pinCmdFreqLo;
        pinRaw[PIN_LOW_POWER_N]   = pinClkLowPowerN;
        pinRaw[PIN_DIV_SELECT]    = pinDataDivSelIn;
        pinRaw[PIN_FREQ_HI]       = pinSelectFreqHi;
        pinRaw[PIN_BUS_DISABLE_N] = busDisableNEff;
    end

    dcpm_pin_sync #(
        .WIDTH     (DCPM_PIN_W),
        .RESET_VAL (PIN_SYNC_RESET)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pinRaw  (pinRaw),
        .syncOut (syncBus.source)
    );

    logic [DCPM_PIN_W-1:0] pinLevel;
    assign pinLevel = syncBus.pinLevel;

    // mode state
    dcpm_mode_t mode_reg;
    dcpm_mode_t mode_next;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            DCPM_MODE_SERIAL: begin
                if (!pinLevel[PIN_BUS_DISABLE_N]) begin
                    mode_next = DCPM_MODE_DIRECT;
                end
            end
            DCPM_MODE_DIRECT: begin
                if (pinLevel[PIN_BUS_DISABLE_N]) begin
                    mode_next = DCPM_MODE_SERIAL;
                end
            end
            default: begin
                mode_next = DCPM_MODE_SERIAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= DCPM_MODE_SERIAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // control registers
    logic [DCPM_REG_W-1:0] genCtrl_reg;
    logic [DCPM_REG_W-1:0] genCtrl_next;
    logic [DCPM_REG_W-1:0] txCtrl_reg;
    logic [DCPM_REG_W-1:0] txCtrl_next;

    always_comb begin
        genCtrl_next = genCtrl_reg;
        txCtrl_next  = txCtrl_reg;
        if (mode_reg == DCPM_MODE_DIRECT) begin
            genCtrl_next = GEN_DIRECT_VAL;
            txCtrl_next  = TX_RESET_VAL;
        end else if (generalReset) begin
            genCtrl_next = GEN_RESET_VAL;
            txCtrl_next  = TX_RESET_VAL;
        end else begin
            // reserved bits are kept at zero whatever is written
            if (wrGenCtrl) begin
                genCtrl_next = wrData & GEN_WRITE_MASK;
            end
            if (wrTxCtrl) begin
                txCtrl_next = wrData & TX_WRITE_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            genCtrl_reg <= GEN_RESET_VAL;
            txCtrl_reg  <= TX_RESET_VAL;
        end else begin
            genCtrl_reg <= genCtrl_next;
            txCtrl_reg  <= txCtrl_next;
        end
    end

    // output decode
    logic                   directMode_next;
    logic                   biasEn_next;
    logic                   modEn_next;
    logic                   div2_next;
    logic [DCPM_FREQ_W-1:0] freq_next;
    logic                   lowPower_next;
    logic                   powersave_next;
    logic                   cmdIn_next;
    logic                   sclk_next;
    logic                   selN_next;
    logic                   pinOut_next;
    logic                   pinOe_next;

    always_comb begin
        directMode_next = 1'b0;
        biasEn_next     = genCtrl_reg[GEN_BIAS_EN_BIT];
        modEn_next      = genCtrl_reg[GEN_MOD_EN_BIT];
        div2_next       = genCtrl_reg[GEN_DIV2_BIT];
        freq_next       = txCtrl_reg[DCPM_FREQ_W-1:0];
        lowPower_next   = 1'b0;
        powersave_next  = !genCtrl_reg[GEN_BIAS_EN_BIT] && !genCtrl_reg[GEN_MOD_EN_BIT];
        cmdIn_next      = 1'b0;
        sclk_next       = 1'b0;
        selN_next       = 1'b1;
        pinOut_next     = 1'b0;
        pinOe_next      = 1'b0;
        if (mode_reg == DCPM_MODE_DIRECT) begin
            directMode_next = 1'b1;
            biasEn_next     = 1'b1;
            modEn_next      = 1'b1;
            div2_next       = !pinLevel[PIN_DIV_SELECT];
            freq_next       = {FREQ_UPPER_DIRECT,
                               pinLevel[PIN_FREQ_HI],
                               pinLevel[PIN_FREQ_LO]};
            lowPower_next   = !pinLevel[PIN_LOW_POWER_N];
            powersave_next  = !pinLevel[PIN_LOW_POWER_N];
        end else begin
            // shared pins carry the serial bus; direct meanings unused
            cmdIn_next  = pinLevel[PIN_FREQ_LO];
            sclk_next   = pinLevel[PIN_LOW_POWER_N];
            selN_next   = pinLevel[PIN_FREQ_HI];
            pinOut_next = serialDataOut;
            pinOe_next  = !pinLevel[PIN_FREQ_HI];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            directMode       <= 1'b0;
            biasSupplyEnable <= 1'b0;
            modulatorEnable  <= 1'b0;
            loDivideByTwo    <= 1'b0;
            loPathFreq       <= '0;
            lowPower         <= 1'b0;
            powersave        <= 1'b1;
            serialCmdIn      <= 1'b0;
            serialClk        <= 1'b0;
            serialSelectN    <= 1'b1;
            pinDataDivSelOut <= 1'b0;
            pinDataDivSelOe  <= 1'b0;
            genCtrlRead      <= GEN_RESET_VAL;
            txCtrlRead       <= TX_RESET_VAL;
        end else begin
            directMode       <= directMode_next;
            biasSupplyEnable <= biasEn_next;
            modulatorEnable  <= modEn_next;
            loDivideByTwo    <= div2_next;
            loPathFreq       <= freq_next;
            lowPower         <= lowPower_next;
            powersave        <= powersave_next;
            serialCmdIn      <= cmdIn_next;
            serialClk        <= sclk_next;
            serialSelectN    <= selN_next;
            pinDataDivSelOut <= pinOut_next;
            pinDataDivSelOe  <= pinOe_next;
            genCtrlRead      <= genCtrl_reg;
            txCtrlRead       <= txCtrl_reg;
        end
    end

endmodule : dcpm_direct_control

// >>> testbench/dcpm_direct_control_props.sv
// assertions on the ports of the direct-control pin mode block
`timescale 1ns/10ps
module dcpm_direct_control_props
    import dcpm_pkg::*;
(
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic                  serialBusDisableNPin,
    input wire logic                  serialBusDisableNDriven,
    input wire logic                  pinCmdFreqLo,
    input wire logic                  pinClkLowPowerN,
    input wire logic                  pinDataDivSelIn,
    input wire logic                  pinDataDivSelOe,
    input wire logic                  pinSelectFreqHi,
    input wire logic                  generalReset,
    input wire logic                  wrGenCtrl,
    input wire logic [DCPM_REG_W-1:0] wrData,
    input wire logic                  directMode,
    input wire logic                  biasSupplyEnable,
    input wire logic                  modulatorEnable,
    input wire logic                  loDivideByTwo,
    input wire logic [DCPM_FREQ_W-1:0] loPathFreq,
    input wire logic                  lowPower,
    input wire logic                  powersave,
    input wire logic [DCPM_REG_W-1:0] genCtrlRead,
    input wire logic [DCPM_REG_W-1:0] txCtrlRead
);
    logic busEff;
    // an undriven pad reads high
    assign busEff = serialBusDisableNPin | ~serialBusDisableNDriven;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_DIRECT_ENTRY: assert property ((!busEff)[*8] |-> directMode)
        else $error("direct mode not entered");
    AST_SERIAL_KEEP: assert property (busEff[*8] |-> !directMode && !lowPower)
        else $error("serial mode not kept");
    AST_DIRECT_EN: assert property (directMode |-> biasSupplyEnable && modulatorEnable)
        else $error("enables not forced");
    AST_DIRECT_HOLD: assert property (directMode && $past(directMode) |->
        genCtrlRead == GEN_DIRECT_VAL && txCtrlRead == TX_RESET_VAL)
        else $error("registers not held");
    AST_FREQ_PINS: assert property (
        (directMode && $stable({pinSelectFreqHi, pinCmdFreqLo}))[*6] |->
        loPathFreq == {FREQ_UPPER_DIRECT, pinSelectFreqHi, pinCmdFreqLo})
        else $error("freq field not from pins");
    AST_DIV_PIN: assert property (
        (directMode && $stable(pinDataDivSelIn))[*6] |-> loDivideByTwo == !pinDataDivSelIn)
        else $error("divider not from pin");
    AST_LOW_POWER: assert property (
        (directMode && $stable(pinClkLowPowerN))[*6] |->
        lowPower == !pinClkLowPowerN && powersave == !pinClkLowPowerN)
        else $error("low power not from pin");
    AST_GEN_WRITE: assert property (busEff[*8] ##0 (wrGenCtrl && !generalReset) |->
        ##2 genCtrlRead == ($past(wrData, 2) & GEN_WRITE_MASK)
        && loDivideByTwo == genCtrlRead[GEN_DIV2_BIT]
        && biasSupplyEnable == genCtrlRead[GEN_BIAS_EN_BIT])
        else $error("general write wrong");
    AST_GEN_RESET: assert property (busEff[*8] ##0 generalReset |->
        ##2 genCtrlRead == GEN_RESET_VAL && txCtrlRead == TX_RESET_VAL && powersave)
        else $error("general reset wrong");
    AST_PIN10_OFF: assert property (directMode |-> !pinDataDivSelOe)
        else $error("pin10 driven in direct mode");
    cover property (directMode && lowPower);
    cover property (busEff && wrGenCtrl);
    cover property (generalReset && wrGenCtrl);
endmodule : dcpm_direct_control_props

bind dcpm_direct_control dcpm_direct_control_props u_props (.ref_clk, .rst_n,
    .serialBusDisableNPin, .serialBusDisableNDriven, .pinCmdFreqLo, .pinClkLowPowerN,
    .pinDataDivSelIn, .pinDataDivSelOe, .pinSelectFreqHi, .generalReset, .wrGenCtrl,
    .wrData, .directMode, .biasSupplyEnable, .modulatorEnable, .loDivideByTwo,
    .loPathFreq, .lowPower, .powersave, .genCtrlRead, .txCtrlRead);

// >>> testbench/dcpm_strap_model.sv
// board strap model driving the shared control pins
`timescale 1ns/10ps
module dcpm_strap_model (
    input  wire logic busLevel,
    input  wire logic busFloat,
    input  wire logic freqLo,
    input  wire logic freqHi,
    input  wire logic lowPowerN,
    input  wire logic divSel,
    input  wire logic pin10Out,
    input  wire logic pin10Oe,
    output logic      busPin,
    output logic      busDriven,
    output logic      pin7,
    output logic      pin9,
    output logic      pin10,
    output logic      pin11
);
    // a floating pad reads low here so that only the pull-up can select serial
    assign busDriven = !busFloat;
    assign busPin    = busFloat ? 1'b0 : busLevel;
    assign pin7      = freqLo;
    assign pin11     = freqHi;
    assign pin9      = lowPowerN;
    assign pin10     = pin10Oe ? pin10Out : divSel;
endmodule : dcpm_strap_model

// >>> testbench/dcpm_direct_control_tb.sv
// self-checking bench for the direct-control pin mode block
`timescale 1ns/10ps
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin nMismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module dcpm_direct_control_tb
    import dcpm_pkg::*;
;
    logic       ref_clk, rst_n, busLevel, busFloat, freqLo, freqHi, lowPowerN, divSel;
    logic       busPin, busDriven, pin7, pin9, pin10, pin11, pin10Out, pin10Oe;
    logic       generalReset, wrGenCtrl, wrTxCtrl, serialDataOut, serialCmdIn, serialClk;
    logic       serialSelectN, directMode, biasSupplyEnable, modulatorEnable;
    logic       loDivideByTwo, lowPower, powersave;
    logic [7:0] wrData, genCtrlRead, txCtrlRead;
    logic [3:0] loPathFreq;
    int         nMismatch = 0;
    int         totalChecks = 0;

    dcpm_strap_model u_strap (.busLevel, .busFloat, .freqLo, .freqHi, .lowPowerN, .divSel,
        .pin10Out, .pin10Oe, .busPin, .busDriven, .pin7, .pin9, .pin10, .pin11);
    dcpm_direct_control u_dut (.ref_clk, .rst_n, .serialBusDisableNPin(busPin),
        .serialBusDisableNDriven(busDriven), .pinCmdFreqLo(pin7), .pinClkLowPowerN(pin9),
        .pinDataDivSelIn(pin10), .pinDataDivSelOut(pin10Out), .pinDataDivSelOe(pin10Oe),
        .pinSelectFreqHi(pin11), .generalReset, .wrGenCtrl, .wrTxCtrl, .wrData,
        .serialDataOut, .serialCmdIn, .serialClk, .serialSelectN, .directMode,
        .biasSupplyEnable, .modulatorEnable, .loDivideByTwo, .loPathFreq, .lowPower,
        .powersave, .genCtrlRead, .txCtrlRead);

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wr(input logic g, input logic t, input logic r, input logic [7:0] d);
        @(negedge ref_clk);
        wrGenCtrl = g;
        wrTxCtrl = t;
        generalReset = r;
        wrData = d;
        @(negedge ref_clk);
        {wrGenCtrl, wrTxCtrl, generalReset} = 3'h0;
        cyc(3);
    endtask : wr

    task automatic t_serial;
        {freqLo, freqHi, lowPowerN, divSel} = 4'h9;
        cyc(8);
        `CHK(directMode, 1'b0)
        `CHK(powersave, 1'b1)
        `CHK({lowPower, serialCmdIn, serialSelectN, pin10Oe, serialClk}, 5'h0A)
        wr(1'b1, 1'b0, 1'b0, 8'hFF);
        `CHK({genCtrlRead, loDivideByTwo, powersave}, {8'h51, 2'h2})
        wr(1'b1, 1'b0, 1'b0, 8'hBE);
        `CHK({loDivideByTwo, biasSupplyEnable, modulatorEnable}, 3'h2)
        wr(1'b0, 1'b1, 1'b0, 8'hA5);
        `CHK({txCtrlRead, loPathFreq}, {8'h05, 4'h5})
        wr(1'b1, 1'b1, 1'b1, 8'hFF);
        `CHK({genCtrlRead, txCtrlRead, powersave}, {16'h0000, 1'b1})
        // select high: clock follows pin9, pin10 released
        {freqHi, lowPowerN, serialDataOut} = 3'h7;
        cyc(8);
        `CHK({serialClk, serialSelectN, pin10Oe, lowPower}, 4'hC)
        freqHi = 1'b0;
        cyc(8);
        `CHK({pin10Oe, pin10Out}, 2'h3)
        {lowPowerN, serialDataOut} = 2'h2;
    endtask : t_serial

    task automatic t_direct;
        busFloat = 1'b0;
        busLevel = 1'b0;
        cyc(8);
        `CHK({directMode, pin10Oe}, 2'h2)
        `CHK({serialCmdIn, serialClk, serialSelectN}, 3'h1)
        `CHK({biasSupplyEnable, modulatorEnable}, 2'h3)
        `CHK({genCtrlRead, txCtrlRead}, {GEN_DIRECT_VAL, TX_RESET_VAL})
        for (int i = 0; i < 8; i++) begin
            {divSel, freqHi, freqLo} = 3'(i);
            cyc(8);
            `CHK(loPathFreq, 4'(i % 4))
            `CHK(loDivideByTwo, !divSel)
        end
        lowPowerN = 1'b0;
        cyc(8);
        `CHK({lowPower, powersave}, 2'h3)
        lowPowerN = 1'b1;
        wr(1'b1, 1'b1, 1'b1, 8'h00);
        `CHK({modulatorEnable, genCtrlRead}, {1'b1, GEN_DIRECT_VAL})
        busFloat = 1'b1;
        cyc(8);
        // registers keep the forced enables after leaving direct mode
        `CHK({directMode, genCtrlRead, biasSupplyEnable}, {1'b0, GEN_DIRECT_VAL, 1'b1})
        wr(1'b1, 1'b0, 1'b0, 8'h40);
        `CHK({genCtrlRead, loDivideByTwo, powersave}, {8'h40, 2'h3})
    endtask : t_direct

    task automatic summarize;
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #100us;
        nMismatch++;
        summarize();
    end

    initial begin
        {rst_n, busLevel, busFloat, freqLo, freqHi, lowPowerN, divSel} = 7'h34;
        {generalReset, wrGenCtrl, wrTxCtrl, serialDataOut, wrData} = 12'h000;
        cyc(16);
        rst_n = 1'b1;
        t_serial();
        t_direct();
        summarize();
    end
endmodule : dcpm_direct_control_tb
